// File: rtl/periph_pkg.sv
// Purpose: shared constants of the peripheral setup block
// Assumes: 25 MHz system clock, 32-bit register port
// Notes: offsets are byte addresses
package periph_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CLK_NS = 40;
  localparam int unsigned PULSE_NS = 15;
  localparam int unsigned PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS < 1 ? 1 :
    (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SEC_CYC = CLK_HZ;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_PRN_ADDR = 8'h08;
  localparam logic [7:0] OFS_DISC_ADDR = 8'h0C;
  localparam logic [7:0] OFS_MIN_DUR = 8'h10;
  localparam logic [7:0] OFS_TOD_DATE = 8'h14;
  localparam logic [7:0] OFS_TOD_TIME = 8'h18;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_BEEP = 3;
  localparam int CTRL_GRAPH = 4;
  localparam int CTRL_AL_IA = 5;
  localparam int CTRL_AL_CFG = 6;
  localparam int CTRL_SAVE = 7;
  localparam logic [31:0] CTRL_RST = 32'h0000_0008;
  localparam logic [5:0] PRN_DEF = 6'h01;
  localparam logic [5:0] PRN_ALT = 6'h02;
  localparam logic [5:0] PRN_MAX = 6'h1E;
  localparam logic [5:0] DISC_DEF = 6'h00;
  localparam logic [5:0] DISC_ALT = 6'h02;
  localparam logic [15:0] MIN_DUR_RST = 16'h0001;
  typedef enum logic [2:0] {
    PM_PULSE = 3'h0,
    PM_HIGH_TIL = 3'h1,
    PM_LOW_TIL = 3'h2,
    PM_LAST_SEQ = 3'h3,
    PM_TIMING = 3'h4,
    PM_CONST_HI = 3'h5,
    PM_CONST_LO = 3'h6
  } port_mode_t;
  typedef enum logic [2:0] {
    OP_LOAD_IA = 3'h1,
    OP_LOAD_CFG = 3'h2,
    OP_SAVE = 3'h3,
    OP_RESET = 3'h4
  } stor_op_t;
endpackage

// File: rtl/rear_port.sv
// Purpose: rear trigger output waveform generator
// Assumes: event inputs come from logic on clk_in
// Notes: output is registered
`timescale 1ns/1ps
`default_nettype none
module rear_port
  import periph_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [2:0] mode_in,
  input wire logic run_start_in,
  input wire logic tracepoint_in,
  input wire logic last_seq_in,
  input wire logic pattern_in,
  input wire logic [15:0] min_dur_in,
  output logic port_out
);
  logic tp_seen_r;
  logic [3:0] pulse_cnt_r;
  logic [15:0] pat_cnt_r;
  wire pulse_act = (pulse_cnt_r != 4'h0);
  wire pat_long = pattern_in && (pat_cnt_r >= min_dur_in);
  logic port_nxt;

  always_comb
  begin
    unique case (mode_in)
      PM_PULSE: port_nxt = pulse_act;
      PM_HIGH_TIL: port_nxt = ~tp_seen_r;
      PM_LOW_TIL: port_nxt = tp_seen_r;
      PM_LAST_SEQ: port_nxt = last_seq_in;
      PM_TIMING: port_nxt = pat_long;
      PM_CONST_HI: port_nxt = 1'b1;
      default: port_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      tp_seen_r <= 1'b0;
      pulse_cnt_r <= 4'h0;
      pat_cnt_r <= 16'h0000;
      port_out <= 1'b0;
    end
    else
    begin
      if (tracepoint_in)
        tp_seen_r <= 1'b1;
      else if (run_start_in)
        tp_seen_r <= 1'b0;
      if (tracepoint_in)
        pulse_cnt_r <= 4'(PULSE_CYC);
      else if (pulse_act)
        pulse_cnt_r <= pulse_cnt_r - 4'h1;
      if (!pattern_in)
        pat_cnt_r <= 16'h0000;
      else if (pat_cnt_r != 16'hFFFF)
        pat_cnt_r <= pat_cnt_r + 16'h0001;
      port_out <= port_nxt;
    end
  end
endmodule
`default_nettype wire

// File: rtl/tod_clock.sv
// Purpose: time-of-day counter, loaded as one complete entry
// Assumes: two-digit year, leap year every fourth year
// Notes: sec_en_in is a one-cycle pulse per second
`timescale 1ns/1ps
`default_nettype none
module tod_clock
  import periph_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic sec_en_in,
  input wire logic set_in,
  input wire logic [31:0] date_in,
  input wire logic [31:0] time_in,
  output logic [31:0] date_out,
  output logic [31:0] time_out
);
  logic [5:0] sec_r, min_r;
  logic [4:0] hour_r, day_r;
  logic [3:0] mon_r;
  logic [6:0] year_r;

  function automatic logic [4:0] days_in(input logic [3:0] m, input logic [6:0] y);
    if (m == 4'd2)
      days_in = (y[1:0] == 2'b00) ? 5'd29 : 5'd28;
    else if (m == 4'd4 || m == 4'd6 || m == 4'd9 || m == 4'd11)
      days_in = 5'd30;
    else
      days_in = 5'd31;
  endfunction

  wire sec_wrap = (sec_r == 6'd59);
  wire min_wrap = sec_wrap && (min_r == 6'd59);
  wire hour_wrap = min_wrap && (hour_r == 5'd23);
  wire day_wrap = hour_wrap && (day_r == days_in(mon_r, year_r));
  wire mon_wrap = day_wrap && (mon_r == 4'd12);
  assign date_out = {12'h000, mon_r, 3'h0, day_r, 1'b0, year_r};
  assign time_out = {11'h000, hour_r, 2'h0, min_r, 2'h0, sec_r};

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      sec_r <= 6'd0;
      min_r <= 6'd0;
      hour_r <= 5'd0;
      day_r <= 5'd1;
      mon_r <= 4'd1;
      year_r <= 7'd0;
    end
    else if (set_in)
    begin
      year_r <= date_in[6:0];
      day_r <= date_in[12:8];
      mon_r <= date_in[19:16];
      sec_r <= time_in[5:0];
      min_r <= time_in[13:8];
      hour_r <= time_in[20:16];
    end
    else if (sec_en_in)
    begin
      sec_r <= sec_wrap ? 6'd0 : sec_r + 6'd1;
      if (sec_wrap)
        min_r <= min_wrap ? 6'd0 : min_r + 6'd1;
      if (min_wrap)
        hour_r <= hour_wrap ? 5'd0 : hour_r + 5'd1;
      if (hour_wrap)
        day_r <= day_wrap ? 5'd1 : day_r + 5'd1;
      if (day_wrap)
        mon_r <= mon_wrap ? 4'd1 : mon_r + 4'd1;
      if (mon_wrap)
        year_r <= (year_r == 7'd99) ? 7'd0 : year_r + 7'd1;
    end
  end
endmodule
`default_nettype wire

// File: rtl/periph_setup.sv
// Purpose: peripheral setup, rear trigger port, beeper, storage sequencing
// Assumes: event inputs from logic on clk_in; switches are pins
// Notes: registers on a plain strobe port, read data one cycle later
//
// Summary of operation
// - tracepoint pulse mode gives one short pulse
// - high from run start until tracepoint
// - low from run start until tracepoint
// - high while seeking final sequence term
// - high while timing pattern outlasts minimum
// - constant modes hold high or low
// - beeper sounds on completion/messages only when enabled
// - switches seven/eight choose interface roles
// - switches one to six give own address
// - printer address default one, two if clash
// - disc address two if analyzer at zero
// - waveform screens always graphics, others selectable
// - autoload yes loads now and at power-up
// - power-up loads inverse assembler before configuration
// - save stores configuration, selection returns no
// - storage failure hides autoload, save retries reset
// - clock runs from complete set entry
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module periph_setup
  import periph_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = SEC_CYC
)
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic [7:0] cfg_sw_in,
  input wire logic run_start_in,
  input wire logic tracepoint_in,
  input wire logic last_seq_in,
  input wire logic pattern_in,
  input wire logic meas_done_in,
  input wire logic msg_flash_in,
  input wire logic waveform_print_in,
  input wire logic nv_autoload_ia_in,
  input wire logic nv_autoload_cfg_in,
  input wire logic stor_fail_in,
  input wire logic stor_done_in,
  input wire logic stor_ok_in,
  output logic rear_port_out,
  output logic beep_out,
  output logic print_graphics_out,
  output logic loop_ext_ctrl_out,
  output logic bus_ctrl_out,
  output logic [5:0] own_addr_out,
  output logic stor_req_out,
  output logic [2:0] stor_op_out,
  output logic autoload_ia_out,
  output logic autoload_cfg_out,
  output logic autoload_shown_out
);
  typedef enum logic [7:0] {
    S_BOOT = 8'b0000_0001,
    S_IDLE = 8'b0000_0010,
    S_PU_IA = 8'b0000_0100,
    S_PU_CFG = 8'b0000_1000,
    S_LD_IA = 8'b0001_0000,
    S_LD_CFG = 8'b0010_0000,
    S_RESET = 8'b0100_0000,
    S_SAVE = 8'b1000_0000
  } seq_state_t;

  seq_state_t state_r, state_nxt;
  logic [7:0] sw_meta_r, sw_r;
  logic [2:0] mode_r;
  logic beep_en_r, graph_r, al_ia_r, al_cfg_r;
  logic failed_r, save_pend_r, ia_pend_r, cfg_pend_r;
  logic [5:0] prn_r;
  logic prn_set_r;
  logic [15:0] min_dur_r;
  logic [31:0] date_stage_r, time_stage_r;
  logic date_staged_r, tod_set_r;
  logic [24:0] sec_cnt_r;
  logic sec_en_r;
  logic [31:0] tod_date, tod_time;

  wire wr_ctrl = reg_wr_in && (reg_addr_in == OFS_CTRL);
  wire wr_prn = reg_wr_in && (reg_addr_in == OFS_PRN_ADDR);
  wire wr_dur = reg_wr_in && (reg_addr_in == OFS_MIN_DUR);
  wire wr_date = reg_wr_in && (reg_addr_in == OFS_TOD_DATE);
  wire wr_time = reg_wr_in && (reg_addr_in == OFS_TOD_TIME);
  wire al_ia_w = reg_wdata_in[CTRL_AL_IA];
  wire al_cfg_w = reg_wdata_in[CTRL_AL_CFG];
  wire al_wr_ok = wr_ctrl && !failed_r;
  wire ia_rise = al_wr_ok && al_ia_w && !al_ia_r;
  wire cfg_rise = al_wr_ok && al_cfg_w && !al_cfg_r;
  wire save_req = wr_ctrl && reg_wdata_in[CTRL_SAVE];

  // switch decode
  wire [1:0] role_sw = sw_r[7:6];
  assign loop_ext_ctrl_out = (role_sw == 2'b10);
  assign bus_ctrl_out = (role_sw != 2'b01);
  assign own_addr_out = sw_r[5:0];

  // address defaults
  wire [5:0] prn_def = (own_addr_out == PRN_DEF) ? PRN_ALT : PRN_DEF;
  wire [5:0] prn_addr = prn_set_r ? prn_r : prn_def;
  wire [5:0] prn_w = reg_wdata_in[5:0];
  wire prn_w_ok = (prn_w <= PRN_MAX) && (prn_w != own_addr_out);
  wire [5:0] disc_addr = (own_addr_out == DISC_DEF) ? DISC_ALT : DISC_DEF;

  assign print_graphics_out = graph_r || waveform_print_in;
  assign beep_out = beep_en_r && (meas_done_in || msg_flash_in);
  assign autoload_ia_out = al_ia_r;
  assign autoload_cfg_out = al_cfg_r;
  assign autoload_shown_out = !failed_r;

  // storage sequencer
  wire done = stor_done_in;
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      S_BOOT:
      begin
        if (stor_fail_in)
          state_nxt = S_IDLE;
        else if (nv_autoload_ia_in)
          state_nxt = S_PU_IA;
        else if (nv_autoload_cfg_in)
          state_nxt = S_PU_CFG;
        else
          state_nxt = S_IDLE;
      end
      S_IDLE:
      begin
        if (save_pend_r)
          state_nxt = failed_r ? S_RESET : S_SAVE;
        else if (ia_pend_r)
          state_nxt = S_LD_IA;
        else if (cfg_pend_r)
          state_nxt = S_LD_CFG;
      end
      S_PU_IA:
        if (done)
          state_nxt = al_cfg_r ? S_PU_CFG : S_IDLE;
      S_RESET:
        if (done)
          state_nxt = stor_ok_in ? S_SAVE : S_IDLE;
      S_PU_CFG, S_LD_IA, S_LD_CFG, S_SAVE:
        if (done)
          state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end

  always_comb
  begin
    unique case (state_r)
      S_PU_IA, S_LD_IA: stor_op_out = OP_LOAD_IA;
      S_PU_CFG, S_LD_CFG: stor_op_out = OP_LOAD_CFG;
      S_SAVE: stor_op_out = OP_SAVE;
      S_RESET: stor_op_out = OP_RESET;
      default: stor_op_out = 3'h0;
    endcase
  end
  assign stor_req_out = (stor_op_out != 3'h0);

  wire seq_save_end = (state_r == S_SAVE) && done;
  wire seq_reset_fail = (state_r == S_RESET) && done && !stor_ok_in;

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      state_r <= S_BOOT;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      sw_meta_r <= 8'h00;
      sw_r <= 8'h00;
    end
    else
    begin
      sw_meta_r <= cfg_sw_in;
      sw_r <= sw_meta_r;
    end
  end

  // control register
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      mode_r <= CTRL_RST[2:0];
      beep_en_r <= CTRL_RST[CTRL_BEEP];
      graph_r <= CTRL_RST[CTRL_GRAPH];
      al_ia_r <= 1'b0;
      al_cfg_r <= 1'b0;
    end
    else if (state_r == S_BOOT)
    begin
      al_ia_r <= nv_autoload_ia_in && !stor_fail_in;
      al_cfg_r <= nv_autoload_cfg_in && !stor_fail_in;
    end
    else if (wr_ctrl)
    begin
      mode_r <= reg_wdata_in[CTRL_MODE_LSB +: 3];
      beep_en_r <= reg_wdata_in[CTRL_BEEP];
      graph_r <= reg_wdata_in[CTRL_GRAPH];
      if (!failed_r)
      begin
        al_ia_r <= al_ia_w;
        al_cfg_r <= al_cfg_w;
      end
    end
  end

  // pending requests: a new request wins over the clear
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      save_pend_r <= 1'b0;
      ia_pend_r <= 1'b0;
      cfg_pend_r <= 1'b0;
      failed_r <= 1'b0;
    end
    else
    begin
      if (save_req)
        save_pend_r <= 1'b1;
      else if (state_r == S_IDLE)
        save_pend_r <= 1'b0;
      if (ia_rise)
        ia_pend_r <= 1'b1;
      else if (state_r == S_IDLE && !save_pend_r)
        ia_pend_r <= 1'b0;
      if (cfg_rise)
        cfg_pend_r <= 1'b1;
      else if (state_r == S_IDLE && !save_pend_r && !ia_pend_r)
        cfg_pend_r <= 1'b0;
      if (state_r == S_BOOT)
        failed_r <= stor_fail_in;
      else if (seq_reset_fail)
        failed_r <= 1'b1;
      else if (seq_save_end)
        failed_r <= !stor_ok_in;
    end
  end

  // address, duration and clock staging
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      prn_r <= PRN_DEF;
      prn_set_r <= 1'b0;
      min_dur_r <= MIN_DUR_RST;
      date_stage_r <= 32'h0000_0000;
      time_stage_r <= 32'h0000_0000;
      date_staged_r <= 1'b0;
      tod_set_r <= 1'b0;
    end
    else
    begin
      if (wr_prn && prn_w_ok)
      begin
        prn_r <= prn_w;
        prn_set_r <= 1'b1;
      end
      if (wr_dur)
        min_dur_r <= reg_wdata_in[15:0];
      if (wr_date)
        date_stage_r <= reg_wdata_in;
      if (wr_time)
        time_stage_r <= reg_wdata_in;
      tod_set_r <= wr_time && date_staged_r;
      if (wr_date)
        date_staged_r <= 1'b1;
      else if (wr_time)
        date_staged_r <= 1'b0;
    end
  end

  // one-second enable
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in || tod_set_r)
    begin
      sec_cnt_r <= 25'd0;
      sec_en_r <= 1'b0;
    end
    else
    begin
      sec_en_r <= (sec_cnt_r == 25'(SEC_CYCLES - 1));
      sec_cnt_r <= (sec_cnt_r == 25'(SEC_CYCLES - 1)) ? 25'd0 : sec_cnt_r + 25'd1;
    end
  end

  // read port
  logic [31:0] rd_mux;
  always_comb
  begin
    unique case (reg_addr_in)
      OFS_CTRL: rd_mux = {24'h00_0000, state_r == S_SAVE || save_pend_r, al_cfg_r, al_ia_r,
        graph_r, beep_en_r, mode_r};
      OFS_STATUS: rd_mux = {16'h0000, !failed_r, stor_req_out, loop_ext_ctrl_out,
        bus_ctrl_out, 6'h00, own_addr_out};
      OFS_PRN_ADDR: rd_mux = {26'h000_0000, prn_addr};
      OFS_DISC_ADDR: rd_mux = {26'h000_0000, disc_addr};
      OFS_MIN_DUR: rd_mux = {16'h0000, min_dur_r};
      OFS_TOD_DATE: rd_mux = tod_date;
      OFS_TOD_TIME: rd_mux = tod_time;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in || !reg_rd_in)
      reg_rdata_out <= 32'h0000_0000;
    else
      reg_rdata_out <= rd_mux;
  end

  rear_port u_port (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .mode_in(mode_r),
    .run_start_in(run_start_in),
    .tracepoint_in(tracepoint_in),
    .last_seq_in(last_seq_in),
    .pattern_in(pattern_in),
    .min_dur_in(min_dur_r),
    .port_out(rear_port_out)
  );

  tod_clock u_tod (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .sec_en_in(sec_en_r),
    .set_in(tod_set_r),
    .date_in(date_stage_r),
    .time_in(time_stage_r),
    .date_out(tod_date),
    .time_out(tod_time)
  );
endmodule
`default_nettype wire

// File: dv/periph_setup_checker.sv
// Purpose: port-level assertions for periph_setup
// Assumes: mode and beeper enable tracked from register writes
// Notes: bound to every periph_setup instance
`timescale 1ns/1ps
`default_nettype none
module periph_setup_checker
  import periph_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] cfg_sw_in,
  input wire logic run_start_in,
  input wire logic tracepoint_in,
  input wire logic last_seq_in,
  input wire logic meas_done_in,
  input wire logic msg_flash_in,
  input wire logic waveform_print_in,
  input wire logic stor_done_in,
  input wire logic rear_port_out,
  input wire logic beep_out,
  input wire logic print_graphics_out,
  input wire logic loop_ext_ctrl_out,
  input wire logic bus_ctrl_out,
  input wire logic [5:0] own_addr_out,
  input wire logic stor_req_out,
  input wire logic [2:0] stor_op_out
);
  logic [2:0] mode_r;
  logic beep_en_r;
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      mode_r <= CTRL_RST[2:0];
      beep_en_r <= CTRL_RST[CTRL_BEEP];
    end
    else if (reg_wr_in && reg_addr_in == OFS_CTRL)
    begin
      mode_r <= reg_wdata_in[2:0];
      beep_en_r <= reg_wdata_in[CTRL_BEEP];
    end
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  pulse_hit_a: assert property (mode_r == PM_PULSE && tracepoint_in ##1 mode_r == PM_PULSE
    |=> rear_port_out) else $error("no pulse after tracepoint");
  pulse_rest_a: assert property (mode_r == PM_PULSE && !tracepoint_in ##1 mode_r == PM_PULSE
    |=> !rear_port_out) else $error("port not resting low");
  high_til_a: assert property (mode_r == PM_HIGH_TIL && (run_start_in || tracepoint_in)
    ##1 mode_r == PM_HIGH_TIL |=> rear_port_out == !$past(tracepoint_in, 2))
    else $error("high-until level wrong");
  low_til_a: assert property (mode_r == PM_LOW_TIL && (run_start_in || tracepoint_in)
    ##1 mode_r == PM_LOW_TIL |=> rear_port_out == $past(tracepoint_in, 2))
    else $error("low-until level wrong");
  last_seq_a: assert property (mode_r == PM_LAST_SEQ |=> rear_port_out == $past(last_seq_in))
    else $error("last sequence level wrong");
  const_hi_a: assert property (mode_r == PM_CONST_HI |=> rear_port_out)
    else $error("constant high broken");
  const_lo_a: assert property (mode_r == PM_CONST_LO |=> !rear_port_out)
    else $error("constant low broken");
  beep_gate_a: assert property (beep_out == (beep_en_r && (meas_done_in || msg_flash_in)))
    else $error("beeper gating wrong");
  graphics_a: assert property (waveform_print_in |-> print_graphics_out)
    else $error("waveform print not graphics");
  sw_decode_a: assert property ($stable(cfg_sw_in) [*4] |-> own_addr_out == cfg_sw_in[5:0]
    && bus_ctrl_out == (cfg_sw_in[7:6] != 2'h1) && loop_ext_ctrl_out == (cfg_sw_in[7:6] == 2'h2))
    else $error("switch decode wrong");
  stor_hold_a: assert property (stor_req_out && !stor_done_in |=> stor_req_out && $stable(stor_op_out))
    else $error("storage request dropped");
  cover property (mode_r == PM_PULSE && tracepoint_in);
  cover property (stor_req_out && stor_op_out == OP_SAVE);
  cover property (mode_r == PM_TIMING && rear_port_out);
endmodule
bind periph_setup periph_setup_checker chk_u (.clk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
  .cfg_sw_in, .run_start_in, .tracepoint_in, .last_seq_in, .meas_done_in, .msg_flash_in, .waveform_print_in,
  .stor_done_in, .rear_port_out, .beep_out, .print_graphics_out, .loop_ext_ctrl_out, .bus_ctrl_out,
  .own_addr_out, .stor_req_out, .stor_op_out);
`default_nettype wire

// File: dv/trig_sink.sv
// Purpose: external instrument on the rear trigger output
// Assumes: samples the port on the system clock
// Notes: counts cycles in which the port is high
`timescale 1ns/1ps
`default_nettype none
module trig_sink (
  input wire logic clk_in,
  input wire logic port_in,
  output var int high_cyc_out
);
  initial high_cyc_out = 0;
  always @(posedge clk_in)
    if (port_in === 1'h1)
      high_cyc_out <= high_cyc_out + 1;
endmodule
`default_nettype wire

// File: dv/peripheral_setup_trigger_port_tb.sv
// Purpose: self-checking bench for periph_setup
// Assumes: second tick shortened to 10 cycles
// Notes: storage partner is served by the serve task
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module peripheral_setup_trigger_port_tb;
  import periph_pkg::*;
  logic clk_in = 1'h0, sys_rst_in = 1'h1, reg_wr_in = 1'h0, reg_rd_in = 1'h0;
  logic [7:0] reg_addr_in = 8'h00, cfg_sw_in = 8'h05;
  logic [31:0] reg_wdata_in = 32'h0000_0000, reg_rdata_out, rv;
  logic run_start_in = 1'h0, tracepoint_in = 1'h0, last_seq_in = 1'h0, pattern_in = 1'h0;
  logic meas_done_in = 1'h0, msg_flash_in = 1'h0, waveform_print_in = 1'h0;
  logic nv_autoload_ia_in = 1'h1, nv_autoload_cfg_in = 1'h1;
  logic stor_fail_in = 1'h0, stor_done_in = 1'h0, stor_ok_in = 1'h1;
  logic rear_port_out, beep_out, print_graphics_out, loop_ext_ctrl_out, bus_ctrl_out;
  logic stor_req_out, autoload_ia_out, autoload_cfg_out, autoload_shown_out;
  logic [5:0] own_addr_out;
  logic [2:0] stor_op_out;
  logic [15:0] rnd = 16'h0005;
  int high_cyc, hb, n_fail = 0, tests_run = 0;
  periph_setup #(.SEC_CYCLES(10)) dut_u (.clk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .cfg_sw_in, .run_start_in, .tracepoint_in, .last_seq_in, .pattern_in,
    .meas_done_in, .msg_flash_in, .waveform_print_in, .nv_autoload_ia_in, .nv_autoload_cfg_in,
    .stor_fail_in, .stor_done_in, .stor_ok_in, .rear_port_out, .beep_out, .print_graphics_out,
    .loop_ext_ctrl_out, .bus_ctrl_out, .own_addr_out, .stor_req_out, .stor_op_out, .autoload_ia_out,
    .autoload_cfg_out, .autoload_shown_out);
  trig_sink sink_u (.clk_in, .port_in(rear_port_out), .high_cyc_out(high_cyc));
  always #20 clk_in = ~clk_in;
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [5:0] prn_exp(input logic [5:0] own);
    return (own == PRN_DEF) ? PRN_ALT : PRN_DEF;
  endfunction
  function automatic logic [5:0] disc_exp(input logic [5:0] own);
    return (own == 6'h00) ? DISC_ALT : DISC_DEF;
  endfunction
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic pulse(input logic tp);
    @(posedge clk_in);
    run_start_in <= !tp;
    tracepoint_in <= tp;
    @(posedge clk_in);
    run_start_in <= 1'h0;
    tracepoint_in <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'h1;
    @(posedge clk_in);
    reg_wr_in <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'h1;
    @(posedge clk_in);
    reg_rd_in <= 1'h0;
    #1;
    rv = reg_rdata_out;
  endtask
  // wait for a storage request, check its kind, then end it
  task automatic serve(input logic [2:0] op, input logic ok);
    int i = 0;
    #1;
    while (stor_req_out !== 1'h1 && i < 60)
    begin
      @(posedge clk_in);
      #1;
      i++;
    end
    if (i == 60)
    begin
      n_fail++;
      wrap_up();
    end
    `CHK(stor_op_out, op)
    @(posedge clk_in);
    stor_ok_in <= ok;
    stor_done_in <= 1'h1;
    @(posedge clk_in);
    stor_done_in <= 1'h0;
  endtask
  task automatic rand_run(input logic ben);
    int ntp = 0, nb = 0, nbx = 0, base;
    base = high_cyc;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clk_in);
      rnd = lfsr(rnd);
      {last_seq_in, msg_flash_in, meas_done_in, tracepoint_in} <= rnd[3:0];
      ntp += rnd[0];
      nbx += ben & (rnd[1] | rnd[2]);
      #1;
      nb += int'(beep_out === 1'h1);
      `CHK(beep_out, ben & (rnd[1] | rnd[2]))
    end
    @(posedge clk_in);
    {last_seq_in, msg_flash_in, meas_done_in, tracepoint_in} <= 4'h0;
    cyc(3);
    `CHK(nb, nbx)
    if (ben) `CHK(high_cyc - base, ntp)
  endtask
  initial
  begin
    cyc(10);
    sys_rst_in <= 1'h0;
    serve(OP_LOAD_IA, 1'h1);
    serve(OP_LOAD_CFG, 1'h1);
    `CHK({autoload_ia_out, autoload_cfg_out}, 2'h3)
    for (int i = 0; i < 6; i++)
    begin
      rnd = lfsr(rnd);
      @(posedge clk_in);
      cfg_sw_in <= {2'(i % 3), (i < 2) ? 6'(i) : rnd[5:0]};
      cyc(4);
      #1;
      `CHK(own_addr_out, cfg_sw_in[5:0])
      `CHK({bus_ctrl_out, loop_ext_ctrl_out}, {i % 3 != 1, i % 3 == 2})
      rd(OFS_PRN_ADDR);
      `CHK(rv[5:0], prn_exp(cfg_sw_in[5:0]))
      rd(OFS_DISC_ADDR);
      `CHK(rv[5:0], disc_exp(cfg_sw_in[5:0]))
    end
    @(posedge clk_in);
    cfg_sw_in <= 8'h05;
    cyc(4);
    wr(OFS_PRN_ADDR, 32'h0000_001F);
    rd(OFS_PRN_ADDR);
    `CHK(rv[5:0], PRN_DEF)
    wr(OFS_PRN_ADDR, 32'h0000_001E);
    wr(OFS_PRN_ADDR, 32'h0000_0005);
    rd(OFS_PRN_ADDR);
    `CHK(rv[5:0], PRN_MAX)
    wr(OFS_CTRL, 32'h0000_0078);
    #1;
    `CHK(print_graphics_out, 1'h1)
    wr(OFS_CTRL, 32'h0000_0068);
    #1;
    `CHK(print_graphics_out, 1'h0)
    @(posedge clk_in);
    waveform_print_in <= 1'h1;
    #1;
    `CHK(print_graphics_out, 1'h1)
    rand_run(1'h1);
    wr(OFS_CTRL, 32'h0000_0063);
    rand_run(1'h0);
    for (int m = 1; m < 7; m++)
    begin
      wr(OFS_CTRL, 32'h0000_0068 | 32'(m));
      pulse(1'h0);
      cyc(2);
      #1;
      if (m < 3) `CHK(rear_port_out, 1'(m == 1))
      if (m > 4) `CHK(rear_port_out, 1'(m == 5))
      pulse(1'h1);
      cyc(2);
      #1;
      if (m < 3) `CHK(rear_port_out, 1'(m == 2))
    end
    wr(OFS_MIN_DUR, 32'h0000_0003);
    wr(OFS_CTRL, 32'h0000_006C);
    for (int l = 3; l < 9; l += 5)
    begin
      hb = high_cyc;
      @(posedge clk_in);
      pattern_in <= 1'h1;
      cyc(l);
      pattern_in <= 1'h0;
      cyc(3);
      `CHK(high_cyc - hb, l - 3)
    end
    wr(OFS_CTRL, 32'h0000_00E8);
    rd(OFS_CTRL);
    `CHK(rv[CTRL_SAVE], 1'h1)
    serve(OP_SAVE, 1'h1);
    rd(OFS_CTRL);
    `CHK(rv[CTRL_SAVE], 1'h0)
    wr(OFS_CTRL, 32'h0000_0048);
    wr(OFS_CTRL, 32'h0000_0068);
    serve(OP_LOAD_IA, 1'h1);
    wr(OFS_TOD_DATE, 32'h0003_0F55);
    wr(OFS_TOD_TIME, 32'h000C_1E05);
    cyc(35);
    rd(OFS_TOD_TIME);
    `CHK(rv[20:0], 21'h0C_1E08)
    rd(OFS_TOD_DATE);
    `CHK(rv[19:0], 20'h3_0F55)
    @(posedge clk_in);
    {nv_autoload_ia_in, nv_autoload_cfg_in, stor_fail_in, sys_rst_in} <= 4'h3;
    cyc(10);
    sys_rst_in <= 1'h0;
    cyc(3);
    #1;
    `CHK(autoload_shown_out, 1'h0)
    wr(OFS_CTRL, 32'h0000_0088);
    serve(OP_RESET, 1'h1);
    serve(OP_SAVE, 1'h1);
    cyc(2);
    #1;
    `CHK(autoload_shown_out, 1'h1)
    wrap_up();
  end
endmodule
`default_nettype wire
